// [hw/charger_config_status_regs.sv]
// Register bank of the two-cell charger: balance/current, timer/converter and status
//
// Functional notes
// - Bit 7 of balance register selects thermistor profile; resets to 1.
// - Bit 6 selects balance start level 3.5V or 3.7V; resets to 0.
// - Bits 5 and 4 select falling and rising mismatch thresholds; reset 0.
// - With 6k resistor, bits 3:0 give 500mA plus binary steps of 100mA.
// - With 24k resistor, same code spans 125mA to 500mA.
// - Current code resets to 1111; whole register resets on POR, soft reset, expiry.
// - Timer bit 7 selects 600kHz or 1200kHz switching; resets to 1.
// - Host writes bit 6 to kick watchdog; expiry leaves this bit alone.
// - Bits 5:4 set watchdog off, 40s, 80s or 160s; reset 01; expiry keeps.
// - Writing 1 to bit 3 restores defaults, then bit clears itself.
// - Bits 2:1 set safety timer off, 8, 20 or 12hrs; reset 10; expiry restores.
// - Bit 0 low suspends and stops boost; high runs boost; resets to 1.
// - Status bits 5:4 report charge phase; reset 00.
// - Status bit 3 is high while input voltage limit loop regulates.
// - Status bit 2 is high when no battery is detected.
// - Status bit 1 is high while die thermal regulation cuts current.
// - Status bit 0 is high while system output sits at minimum level.
// - Slave address 4BH; single-byte writes and reads only.
// - Undefined register address gets NACK and return to idle.
`timescale 1ns/1ns
module charger_config_status_regs
  import charger_regs_pkg::*;
#(
  parameter longint WD_CYC_LIM_40 = WD_CYC_40,
  parameter longint WD_CYC_LIM_80 = WD_CYC_80,
  parameter longint WD_CYC_LIM_160 = WD_CYC_160
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Charger core status
  input wire status_in_t status_in,
  // Current-set resistor strap: 0 = 6k, 1 = 24k
  input wire logic current_set_resistor,
  // Configuration to the charger core
  output config_out_t cfg,
  // Fast-charge current target in mA
  output logic [11:0] fast_charge_ma,
  // One-cycle pulse on watchdog expiry
  output logic watchdog_expiry
);

  // ************************************************************
  // Local signals
  // ************************************************************
  logic [7:0] bal_cur;
  logic [7:0] timer_cfg;
  logic [5:0] status;
  logic [7:0] reg_ptr;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic ptr_valid;
  logic engine_oe;
  logic soft_rst;
  logic [34:0] wd_cnt;
  logic [34:0] wd_lim;
  logic wd_fire;

  // ************************************************************
  // Bus engine
  // ************************************************************
  i2c_byte_slave u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(engine_oe),
    .reg_ptr(reg_ptr),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .ptr_valid(ptr_valid)
  );

  assign ptr_valid = (reg_ptr == OFS_BAL_CUR) || (reg_ptr == OFS_TIMER) ||
    (reg_ptr == OFS_STATUS);

  // Open drain: output only ever drives low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end
  assign sda_oe = engine_oe;

  // ************************************************************
  // Read mux
  // ************************************************************
  always_comb begin
    case (reg_ptr)
      OFS_BAL_CUR: rd_data = bal_cur;
      OFS_TIMER: rd_data = {timer_cfg[7:4], 1'b0, timer_cfg[2:0]};
      OFS_STATUS: rd_data = {2'b00, status};
      default: rd_data = 8'h00;
    endcase
  end

  assign soft_rst = wr_stb && (reg_ptr == OFS_TIMER) && wr_data[BIT_SOFT_RST];

  // ************************************************************
  // Balance and current register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bal_cur <= RST_BAL_CUR;
    end else if (soft_rst || wd_fire) begin
      bal_cur <= RST_BAL_CUR;
    end else if (wr_stb && reg_ptr == OFS_BAL_CUR) begin
      bal_cur <= wr_data;
    end
  end

  // ************************************************************
  // Timer and converter register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_cfg <= RST_TIMER;
    end else if (soft_rst) begin
      timer_cfg <= RST_TIMER;
    end else if (wd_fire) begin
      // Expiry keeps kick and limit, restores the rest
      timer_cfg <= (timer_cfg & WD_KEEP_MASK_TIMER) | (RST_TIMER & ~WD_KEEP_MASK_TIMER);
    end else if (wr_stb && reg_ptr == OFS_TIMER) begin
      timer_cfg <= {wr_data[7:4], 1'b0, wr_data[2:0]};
    end
  end

  // ************************************************************
  // Status capture
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= RST_STATUS[5:0];
    end else begin
      status <= {status_in.charge_phase, status_in.input_limit_active,
        status_in.battery_absent, status_in.thermal_limit_active,
        status_in.sys_min_reg_active};
    end
  end

  // ************************************************************
  // Serial-bus watchdog
  // ************************************************************
  always_comb begin
    case (timer_cfg[BIT_WD_LIM_HI:BIT_WD_LIM_LO])
      2'b01: wd_lim = WD_CYC_LIM_40[34:0];
      2'b10: wd_lim = WD_CYC_LIM_80[34:0];
      2'b11: wd_lim = WD_CYC_LIM_160[34:0];
      default: wd_lim = 35'h0;
    endcase
  end

  assign wd_fire = (wd_lim != 35'h0) && (wd_cnt >= wd_lim - 35'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt <= 35'h0;
    end else if (wd_lim == 35'h0 || wd_fire || soft_rst) begin
      wd_cnt <= 35'h0;
    end else if (wr_stb && reg_ptr == OFS_TIMER && wr_data[BIT_WD_KICK]) begin
      wd_cnt <= 35'h0;
    end else begin
      wd_cnt <= wd_cnt + 35'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_expiry <= 1'b0;
    end else begin
      watchdog_expiry <= wd_fire;
    end
  end

  // ************************************************************
  // Decoded outputs
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
      fast_charge_ma <= 12'h000;
    end else begin
      cfg.thermistor_profile_sel <= bal_cur[BIT_THERM_PROFILE];
      cfg.bal_start_high <= bal_cur[BIT_BAL_START];
      cfg.balance_thresh_falling <= bal_cur[BIT_THRESH_FALL];
      cfg.balance_thresh_rising <= bal_cur[BIT_THRESH_RISE];
      cfg.icc_code <= bal_cur[BIT_ICC_HI:0];
      cfg.switch_freq_sel <= timer_cfg[BIT_SW_FREQ];
      cfg.watchdog_limit <= timer_cfg[BIT_WD_LIM_HI:BIT_WD_LIM_LO];
      cfg.safety_timer_sel <= timer_cfg[BIT_SAFE_HI:BIT_SAFE_LO];
      cfg.boost_run <= timer_cfg[BIT_BOOST_RUN];
      if (current_set_resistor) begin
        fast_charge_ma <= 12'h07D + 12'h019 * {8'h00, bal_cur[3:0]};
      end else begin
        fast_charge_ma <= 12'h1F4 + 12'h064 * {8'h00, bal_cur[3:0]};
      end
    end
  end

endmodule

// [include/charger_regs_pkg.sv]
// Package with register map, field layout, reset values and timing for the charger register bank
package charger_regs_pkg;

  // ************************************************************
  // Bus identity and register offsets
  // ************************************************************
  localparam logic [6:0] SLAVE_ADDR = 7'h4B;
  localparam logic [7:0] OFS_BAL_CUR = 8'h01;
  localparam logic [7:0] OFS_TIMER = 8'h02;
  localparam logic [7:0] OFS_STATUS = 8'h03;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_BAL_CUR = 8'h8F;
  localparam logic [7:0] RST_TIMER = 8'h95;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_THERM_PROFILE = 7;
  localparam int BIT_BAL_START = 6;
  localparam int BIT_THRESH_FALL = 5;
  localparam int BIT_THRESH_RISE = 4;
  localparam int BIT_ICC_HI = 3;
  localparam int BIT_SW_FREQ = 7;
  localparam int BIT_WD_KICK = 6;
  localparam int BIT_WD_LIM_HI = 5;
  localparam int BIT_WD_LIM_LO = 4;
  localparam int BIT_SOFT_RST = 3;
  localparam int BIT_SAFE_HI = 2;
  localparam int BIT_SAFE_LO = 1;
  localparam int BIT_BOOST_RUN = 0;

  // Bits that watchdog expiry leaves alone in the timer register
  localparam logic [7:0] WD_KEEP_MASK_TIMER = 8'h78;

  // ************************************************************
  // Watchdog limits in seconds and cycles at 125 MHz
  // ************************************************************
  localparam longint CLK_HZ = 125000000;
  localparam longint WD_S_40 = 40;
  localparam longint WD_S_80 = 80;
  localparam longint WD_S_160 = 160;
  localparam longint WD_CYC_40 = WD_S_40 * CLK_HZ;
  localparam longint WD_CYC_80 = WD_S_80 * CLK_HZ;
  localparam longint WD_CYC_160 = WD_S_160 * CLK_HZ;

  // Live status inputs of the charger core
  typedef struct packed {
    logic [1:0] charge_phase;
    logic input_limit_active;
    logic battery_absent;
    logic thermal_limit_active;
    logic sys_min_reg_active;
  } status_in_t;

  // Decoded configuration outputs
  typedef struct packed {
    logic thermistor_profile_sel;
    logic bal_start_high;
    logic balance_thresh_falling;
    logic balance_thresh_rising;
    logic [3:0] icc_code;
    logic switch_freq_sel;
    logic [1:0] watchdog_limit;
    logic [1:0] safety_timer_sel;
    logic boost_run;
  } config_out_t;

endpackage

// [hw/i2c_byte_slave.sv]
// I2C slave engine: address match, register pointer, single-byte read and write
`timescale 1ns/1ns
module i2c_byte_slave
  import charger_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins, sampled synchronously
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // Register side
  output logic [7:0] reg_ptr,
  output logic wr_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic ptr_valid
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_ACK = 3'b101,
    ST_RACK = 3'b110
  } state_t;

  state_t state;
  state_t after_ack;
  logic scl_d;
  logic sda_d;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic nack_hold;

  wire scl_rise = scl_in & ~scl_d;
  wire scl_fall = ~scl_in & scl_d;
  wire start_cond = scl_in & scl_d & sda_d & ~sda_in;
  wire stop_cond = scl_in & scl_d & ~sda_d & sda_in;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end

  // ************************************************************
  // Protocol state machine
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      sda_oe <= 1'b0;
      reg_ptr <= 8'h00;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      nack_hold <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (start_cond) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              nack_hold <= 1'b0;
              state <= ST_ACK;
              if (state == ST_ADDR) begin
                if (shreg[7:1] != SLAVE_ADDR) begin
                  state <= ST_IDLE;
                end else begin
                  sda_oe <= 1'b1;
                  after_ack <= shreg[0] ? ST_RDATA : ST_PTR;
                end
              end else if (state == ST_PTR) begin
                reg_ptr <= shreg;
                after_ack <= ST_WDATA;
                // Undefined register answered with NACK
                sda_oe <= (shreg == OFS_BAL_CUR) || (shreg == OFS_TIMER) ||
                  (shreg == OFS_STATUS);
                nack_hold <= !((shreg == OFS_BAL_CUR) || (shreg == OFS_TIMER) ||
                  (shreg == OFS_STATUS));
              end else begin
                wr_stb <= ptr_valid;
                wr_data <= shreg;
                sda_oe <= ptr_valid;
                after_ack <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              if (nack_hold) begin
                state <= ST_IDLE;
              end else if (after_ack == ST_RDATA) begin
                state <= ST_RDATA;
                shreg <= rd_data;
                sda_oe <= ~rd_data[7];
                bit_cnt <= 4'h1;
              end else begin
                state <= after_ack;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe <= 1'b0;
                state <= ST_RACK;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            // Single-byte read only; master ends with NACK and stop
            if (scl_fall) begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// [sim/charger_regs_sva.sv]
// Concurrent checks on the charger register bank ports
`timescale 1ns/1ns
module charger_regs_sva
  import charger_regs_pkg::*;
#(
  parameter longint WD_CYC_LIM_40 = 1,
  parameter longint WD_CYC_LIM_80 = 1,
  parameter longint WD_CYC_LIM_160 = 1
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Core side
  input wire status_in_t status_in,
  input wire logic current_set_resistor,
  input wire config_out_t cfg,
  input wire logic [11:0] fast_charge_ma,
  input wire logic watchdog_expiry
);
  // ********
  // Checks
  // ********
  logic [1:0] run;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) run <= 2'h0;
    else if (run != 2'h3) run <= run + 2'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe moved while scl high");
  AST_EXP_PULSE: assert property (watchdog_expiry |=> !watchdog_expiry)
    else $error("expiry pulse too long");
  AST_EXP_NEEDS_LIM: assert property (watchdog_expiry |-> cfg.watchdog_limit != 2'h0)
    else $error("expiry with watchdog off");
  AST_EXP_KEEP_LIM: assert property (watchdog_expiry |=>
    $stable(cfg.watchdog_limit) [*2])
    else $error("expiry changed limit");
  AST_EXP_BAL: assert property (watchdog_expiry |-> ##[0:2] cfg[13:6] == 8'h8F)
    else $error("expiry did not restore balance");
  AST_EXP_TMR: assert property (watchdog_expiry |->
    ##[0:2] {cfg.switch_freq_sel, cfg.safety_timer_sel, cfg.boost_run} == 4'hD)
    else $error("expiry did not restore timer");
  AST_MA_6K: assert property ((!current_set_resistor && $stable(cfg.icc_code)) [*3]
    |-> fast_charge_ma == 12'h1F4 + 12'h064 * cfg.icc_code)
    else $error("6k current wrong");
  AST_MA_24K: assert property ((current_set_resistor && $stable(cfg.icc_code)) [*3]
    |-> fast_charge_ma == 12'h07D + 12'h019 * cfg.icc_code)
    else $error("24k current wrong");
  AST_CFG_CAUSE: assert property ($changed(cfg) && run == 2'h3
    |-> sda_oe || watchdog_expiry || $past(watchdog_expiry) || $past(watchdog_expiry, 2))
    else $error("cfg changed without cause");
  cover property (watchdog_expiry);
  cover property ($rose(sda_oe));
  cover property (current_set_resistor && fast_charge_ma == 12'h177);
endmodule

bind charger_config_status_regs charger_regs_sva #(
  .WD_CYC_LIM_40(WD_CYC_LIM_40),
  .WD_CYC_LIM_80(WD_CYC_LIM_80),
  .WD_CYC_LIM_160(WD_CYC_LIM_160)
) u_sva (.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .status_in(status_in), .current_set_resistor(current_set_resistor),
  .cfg(cfg), .fast_charge_ma(fast_charge_ma), .watchdog_expiry(watchdog_expiry));

// [sim/i2c_host_model.sv]
// Two-wire bus master model for single-byte register transfers
`timescale 1ns/1ns
module i2c_host_model (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ********
  // Bus cycles
  // ********
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold();
    repeat (5) @(posedge clk);
  endtask
  task automatic bit_io(input logic v, output logic s);
    sda_low <= ~v;
    hold();
    scl <= 1'b1;
    hold();
    s = sda;
    scl <= 1'b0;
    hold();
  endtask
  task automatic start();
    sda_low <= 1'b0;
    scl <= 1'b1;
    hold();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b0;
    hold();
  endtask
  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
    output logic [2:0] ak);
    start();
    byte_out({a, 1'b0}, ak[2]);
    byte_out(p, ak[1]);
    byte_out(d, ak[0]);
    stop();
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
    output logic [2:0] ak);
    logic s;
    start();
    byte_out({a, 1'b0}, ak[2]);
    byte_out(p, ak[1]);
    start();
    byte_out({a, 1'b1}, ak[0]);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, s);
    stop();
  endtask
endmodule

// [sim/charger_config_status_regs_test.sv]
// Self-checking bench for the charger register bank
`timescale 1ns/1ns
module charger_config_status_regs_test
  import charger_regs_pkg::*;
;
  // ********
  // Bench
  // ********
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic res = 1'b0;
  status_in_t status_in = '0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  config_out_t cfg;
  logic [11:0] ma;
  logic wd_exp;
  logic [7:0] t;
  logic [7:0] v;
  logic [2:0] ak;
  wire sda = ~(sda_oe | sda_low);
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  int lim;
  always #4 clk = ~clk;
  charger_config_status_regs #(.WD_CYC_LIM_40(3000), .WD_CYC_LIM_80(6000),
    .WD_CYC_LIM_160(12000)) DUT (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .status_in(status_in), .current_set_resistor(res),
    .cfg(cfg), .fast_charge_ma(ma), .watchdog_expiry(wd_exp));
  i2c_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_cfg(input logic [7:0] b, input logic [7:0] r);
    chk({2'h0, cfg}, {2'h0, b, r[7], r[5:4], r[2:1], r[0]}, "cfg");
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [2:0] a;
    u_host.write_reg(SLAVE_ADDR, p, d, a);
    chk({13'h0, a}, 16'h0007, "write ack");
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    logic [2:0] a;
    u_host.read_reg(SLAVE_ADDR, p, d, a);
    chk({13'h0, a}, 16'h0007, "read ack");
    chk({8'h0, d}, {8'h0, e}, "read data");
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #600000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk_cfg(8'h8F, 8'h95);
    chk({4'h0, ma}, 16'h07D0, "ma reset");
    rd_chk(OFS_BAL_CUR, 8'h8F);
    rd_chk(OFS_TIMER, 8'h95);
    rd_chk(OFS_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      t = {i[0], 3'h0, 1'b0, i[1:0], i[1]};
      wr(OFS_TIMER, t);
      chk_cfg(8'h8F, t);
      rd_chk(OFS_TIMER, t);
    end
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h5A : (i == 1) ? 8'hA5 : 8'h00;
      wr(OFS_BAL_CUR, v);
      chk_cfg(v, t);
      chk({4'h0, ma}, 16'h01F4 + 16'h0064 * v[3:0], "ma 6k");
      res <= 1'b1;
      repeat (3) @(posedge clk);
      chk({4'h0, ma}, 16'h007D + 16'h0019 * v[3:0], "ma 24k");
      res <= 1'b0;
      rd_chk(OFS_BAL_CUR, v);
    end
    for (int i = 0; i < 4; i++) begin
      status_in <= status_in_t'((i == 0) ? 6'h3F : (i == 1) ? 6'h15 : (i == 2) ? 6'h2A : 6'h00);
      wr(OFS_STATUS, 8'hFF);
      rd_chk(OFS_STATUS, {2'h0, status_in});
    end
    u_host.write_reg(7'h4A, OFS_BAL_CUR, 8'hFF, ak);
    chk({13'h0, ak}, 16'h0000, "foreign address");
    u_host.write_reg(SLAVE_ADDR, 8'h04, 8'hFF, ak);
    chk({13'h0, ak}, 16'h0004, "pointer 4");
    u_host.write_reg(SLAVE_ADDR, 8'h00, 8'hFF, ak);
    chk({13'h0, ak}, 16'h0004, "pointer 0");
    rd_chk(OFS_BAL_CUR, v);
    wr(OFS_TIMER, 8'h08);
    chk_cfg(8'h8F, 8'h95);
    rd_chk(OFS_TIMER, 8'h95);
    rd_chk(OFS_BAL_CUR, 8'h8F);
    for (int c = 1; c < 4; c++) begin
      t = {2'h1, c[1:0], 4'h0};
      lim = (c == 1) ? 3000 : (c == 2) ? 6000 : 12000;
      wr(OFS_BAL_CUR, 8'h00);
      wr(OFS_TIMER, t);
      repeat (1500) @(posedge clk);
      wr(OFS_TIMER, t);
      n = 0;
      while (wd_exp !== 1'b1 && n < 20000) begin
        @(posedge clk);
        n++;
      end
      chk({15'h0, n > lim - 100 && n <= lim + 20}, 16'h0001, "watchdog span");
      repeat (3) @(posedge clk);
      chk_cfg(8'h8F, (t & 8'h78) | 8'h85);
      rd_chk(OFS_TIMER, (t & 8'h78) | 8'h85);
      rd_chk(OFS_BAL_CUR, 8'h8F);
    end
    wr(OFS_TIMER, 8'h85);
    end_of_test();
  end
endmodule
